// [logic/gpc_port_pkg.sv]
package gpc_port_pkg;

   // ----------------------------------------------------------------
   // Register addresses
   // ----------------------------------------------------------------
   localparam logic [15:0] ADDR_PORT2_DATA  = 16'hFF02;
   localparam logic [15:0] ADDR_PORT3_DATA  = 16'hFF03;
   localparam logic [15:0] ADDR_PORT4_DATA  = 16'hFF04;
   localparam logic [15:0] ADDR_PORT12_DATA = 16'hFF0C;
   localparam logic [15:0] ADDR_PORT13_DATA = 16'hFF0D;
   localparam logic [15:0] ADDR_DIR_PORT2   = 16'hFF22;
   localparam logic [15:0] ADDR_DIR_PORT3   = 16'hFF23;
   localparam logic [15:0] ADDR_DIR_PORT4   = 16'hFF24;
   localparam logic [15:0] ADDR_DIR_PORT12  = 16'hFF2C;
   localparam logic [15:0] ADDR_PU_PORT2    = 16'hFF32;
   localparam logic [15:0] ADDR_PU_PORT3    = 16'hFF33;
   localparam logic [15:0] ADDR_PU_PORT4    = 16'hFF34;
   localparam logic [15:0] ADDR_PU_PORT12   = 16'hFF3C;
   localparam logic [15:0] ADDR_ANALOG_SEL  = 16'hFF84;

   // ----------------------------------------------------------------
   // Implemented bit masks per port
   // ----------------------------------------------------------------
   localparam logic [7:0] MASK_PORT2   = 8'h0F;
   localparam logic [7:0] MASK_PORT3   = 8'h13;
   localparam logic [7:0] MASK_PORT3WR = 8'h03;   // Latch bits; bit 4 is input only
   localparam logic [7:0] MASK_PORT3IN = 8'h10;   // Input-only pin position
   localparam logic [7:0] MASK_PORT4   = 8'h3F;
   localparam logic [7:0] MASK_PORT12  = 8'h0E;
   localparam logic [7:0] MASK_PORT13  = 8'h01;
   localparam logic [7:0] MASK_PULL_UP_ENABLE_PORT12    = 8'h08;   // Only bit 3 has a pull-up

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_DIR   = 8'hFF;
   localparam logic [7:0] RST_PU    = 8'h00;
   localparam logic [7:0] RST_ASEL  = 8'h00;
   localparam logic [7:0] RD_NONE   = 8'h00;   // Answer for unmapped reads

   // ----------------------------------------------------------------
   // Pin group carried as one struct
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] port2;
      logic [7:0] port3;
      logic [7:0] port4;
      logic [7:0] port12;
      logic [7:0] port13;
   } gpc_pins_s;

endpackage : gpc_port_pkg

// [logic/gpc_pin_sync.sv]
// --------------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// --------------------------------------------------------------------
module gpc_pin_sync #(
   parameter int WIDTH = 40
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             sys_rst,
   // Asynchronous pins in, filtered levels out
   input  wire logic [WIDTH-1:0] pinAsync,
   output logic      [WIDTH-1:0] pinLevel
);

   logic [WIDTH-1:0] stage1_ff;      // Metastability catcher, read by stage2 only
   logic [WIDTH-1:0] stage2_ff;      // Second stage
   logic [WIDTH-1:0] stage3_ff;      // Third stage
   logic [WIDTH-1:0] level_ff;       // Accepted level
   logic [WIDTH-1:0] nxt_level;      // Next accepted level

   // Accept a bit only where the second and third stages agree
   always_comb begin
      nxt_level = (stage2_ff & ~(stage2_ff ^ stage3_ff)) | (level_ff & (stage2_ff ^ stage3_ff));
   end

   // Stage registers
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1_ff <= '0;
         stage2_ff <= '0;
         stage3_ff <= '0;
         level_ff  <= '0;
      end else begin
         stage1_ff <= pinAsync;
         stage2_ff <= stage1_ff;
         stage3_ff <= stage2_ff;
         level_ff  <= nxt_level;
      end
   end

   assign pinLevel = level_ff;

endmodule : gpc_pin_sync

// [logic/gpc_port_regs.sv]
// Notes on behaviour
// - Five data registers; unused bits read zero
// - Port 3 bit 4 input only, unwritable
// - Latch drives pin; read gives pin level in input mode
// - Analog select bit per port 2 pin
// - Analog select clears to zero on reset
// - Pull-up enables for ports 2, 3, 4, 12
// - Pull-ups bit/byte writable, reset to zero
// - Direction 0 output, 1 input; reset ones
// - Read gives pin in input, latch in output
// - Pull-up only acts in input mode
module gpc_port_regs (
   // Clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   // Core memory access
   input  wire logic [15:0]            memAddr,
   input  wire logic                   memRdEn,
   input  wire logic                   memByteWr,
   input  wire logic                   memBitWr,
   input  wire logic [7:0]             memWrData,
   input  wire logic [2:0]             memBitSel,
   input  wire logic                   memBitVal,
   output logic      [7:0]             memRdData,
   output logic                        memRdValid,
   // Pins
   input  wire gpc_port_pkg::gpc_pins_s pinIn,
   output gpc_port_pkg::gpc_pins_s      pinOut,
   output gpc_port_pkg::gpc_pins_s      pinOe,
   output gpc_port_pkg::gpc_pins_s      pullUpOn,
   // Converter input routing
   output logic      [3:0]             analogInputs
);
   import gpc_port_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Byte or single-bit write, limited to implemented bits
   function automatic logic [7:0] applyWrite(input logic [7:0] old, input logic hit,
                                             input logic [7:0] mask, input logic byteWr,
                                             input logic bitWr, input logic [7:0] data,
                                             input logic [2:0] sel, input logic val);
      logic [7:0] one;
      logic [7:0] res;
      one = 8'h01 << sel;
      res = old;
      if (hit && byteWr) begin
         res = data;
      end else if (hit && bitWr) begin
         res = val ? (old | one) : (old & ~one);
      end
      return (res & mask) | (old & ~mask);
   endfunction : applyWrite

   // Per-bit read: pin in input mode, latch in output mode
   function automatic logic [7:0] readPort(input logic [7:0] dir, input logic [7:0] pin,
                                           input logic [7:0] latch, input logic [7:0] mask);
      return ((dir & pin) | (~dir & latch)) & mask;
   endfunction : readPort

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   gpc_pins_s  latch_ff;             // Output latches
   gpc_pins_s  nxt_latch;
   gpc_pins_s  dir_ff;               // Direction, 1 = input
   gpc_pins_s  nxt_dir;
   gpc_pins_s  pu_ff;                // Pull-up enables
   gpc_pins_s  nxt_pu;
   logic [7:0] asel_ff;              // Port 2 analog select
   logic [7:0] nxt_asel;
   logic [7:0] rdData_ff;            // Read answer
   logic [7:0] nxt_rdData;
   logic       rdValid_ff;           // Read answer valid
   logic       nxt_rdValid;
   gpc_pins_s  pinSync;              // Synchronised pin levels

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   gpc_pin_sync #(
      .WIDTH ($bits(gpc_pins_s))
   ) u_sync (
      .sys_clk  (sys_clk),
      .sys_rst  (sys_rst),
      .pinAsync (pinIn),
      .pinLevel (pinSync)
   );

   // ----------------------------------------------------------------
   // Next-state computation
   // ----------------------------------------------------------------

   // Register writes and read answer
   always_comb begin
      nxt_latch = latch_ff;
      nxt_dir   = dir_ff;
      nxt_pu    = pu_ff;
      // Output latches; port 3 bit 4 excluded from write
      nxt_latch.port2  = applyWrite(latch_ff.port2, memAddr == ADDR_PORT2_DATA, MASK_PORT2,
                                    memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_latch.port3  = applyWrite(latch_ff.port3, memAddr == ADDR_PORT3_DATA, MASK_PORT3WR,
                                    memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_latch.port4  = applyWrite(latch_ff.port4, memAddr == ADDR_PORT4_DATA, MASK_PORT4,
                                    memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_latch.port12 = applyWrite(latch_ff.port12, memAddr == ADDR_PORT12_DATA, MASK_PORT12,
                                    memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_latch.port13 = applyWrite(latch_ff.port13, memAddr == ADDR_PORT13_DATA, MASK_PORT13,
                                    memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      // Direction registers, unimplemented bits stay one
      nxt_dir.port2  = applyWrite(dir_ff.port2, memAddr == ADDR_DIR_PORT2, MASK_PORT2,
                                  memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_dir.port3  = applyWrite(dir_ff.port3, memAddr == ADDR_DIR_PORT3, MASK_PORT3WR,
                                  memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_dir.port4  = applyWrite(dir_ff.port4, memAddr == ADDR_DIR_PORT4, MASK_PORT4,
                                  memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_dir.port12 = applyWrite(dir_ff.port12, memAddr == ADDR_DIR_PORT12, MASK_PORT12,
                                  memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      // Pull-up enables
      nxt_pu.port2  = applyWrite(pu_ff.port2, memAddr == ADDR_PU_PORT2, MASK_PORT2,
                                 memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_pu.port3  = applyWrite(pu_ff.port3, memAddr == ADDR_PU_PORT3, MASK_PORT3WR,
                                 memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_pu.port4  = applyWrite(pu_ff.port4, memAddr == ADDR_PU_PORT4, MASK_PORT4,
                                 memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      nxt_pu.port12 = applyWrite(pu_ff.port12, memAddr == ADDR_PU_PORT12, MASK_PULL_UP_ENABLE_PORT12,
                                 memByteWr, memBitWr, memWrData, memBitSel, memBitVal);
      // Analog select, port 2 pins only
      nxt_asel = applyWrite(asel_ff, memAddr == ADDR_ANALOG_SEL, MASK_PORT2,
                            memByteWr, memBitWr, memWrData, memBitSel, memBitVal);

      // Read decode
      nxt_rdValid = memRdEn;
      nxt_rdData  = rdData_ff;
      if (memRdEn) begin
         if (memAddr == ADDR_PORT2_DATA) begin
            nxt_rdData = readPort(dir_ff.port2, pinSync.port2, latch_ff.port2, MASK_PORT2);
         end else if (memAddr == ADDR_PORT3_DATA) begin
            // Bit 4 always follows its pin
            nxt_rdData = readPort(dir_ff.port3 | MASK_PORT3IN, pinSync.port3, latch_ff.port3,
                                  MASK_PORT3);
         end else if (memAddr == ADDR_PORT4_DATA) begin
            nxt_rdData = readPort(dir_ff.port4, pinSync.port4, latch_ff.port4, MASK_PORT4);
         end else if (memAddr == ADDR_PORT12_DATA) begin
            nxt_rdData = readPort(dir_ff.port12, pinSync.port12, latch_ff.port12,
                                  MASK_PORT12);
         end else if (memAddr == ADDR_PORT13_DATA) begin
            nxt_rdData = latch_ff.port13 & MASK_PORT13;
         end else if (memAddr == ADDR_DIR_PORT2) begin
            nxt_rdData = dir_ff.port2;
         end else if (memAddr == ADDR_DIR_PORT3) begin
            nxt_rdData = dir_ff.port3;
         end else if (memAddr == ADDR_DIR_PORT4) begin
            nxt_rdData = dir_ff.port4;
         end else if (memAddr == ADDR_DIR_PORT12) begin
            nxt_rdData = dir_ff.port12;
         end else if (memAddr == ADDR_PU_PORT2) begin
            nxt_rdData = pu_ff.port2;
         end else if (memAddr == ADDR_PU_PORT3) begin
            nxt_rdData = pu_ff.port3;
         end else if (memAddr == ADDR_PU_PORT4) begin
            nxt_rdData = pu_ff.port4;
         end else if (memAddr == ADDR_PU_PORT12) begin
            nxt_rdData = pu_ff.port12;
         end else if (memAddr == ADDR_ANALOG_SEL) begin
            nxt_rdData = asel_ff;
         end else begin
            nxt_rdData = RD_NONE;
         end
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         latch_ff   <= {5{RST_LATCH}};
         dir_ff     <= {5{RST_DIR}};
         pu_ff      <= {5{RST_PU}};
         asel_ff    <= RST_ASEL;
         rdData_ff  <= RD_NONE;
         rdValid_ff <= 1'b0;
      end else begin
         latch_ff   <= nxt_latch;
         dir_ff     <= nxt_dir;
         pu_ff      <= nxt_pu;
         asel_ff    <= nxt_asel;
         rdData_ff  <= nxt_rdData;
         rdValid_ff <= nxt_rdValid;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------

   // Latch value drives pin where the buffer is on
   always_comb begin
      pinOut        = latch_ff;
      pinOe.port2   = ~dir_ff.port2 & MASK_PORT2;
      pinOe.port3   = ~dir_ff.port3 & MASK_PORT3WR;
      pinOe.port4   = ~dir_ff.port4 & MASK_PORT4;
      pinOe.port12  = ~dir_ff.port12 & MASK_PORT12;
      pinOe.port13  = MASK_PORT13;
      // Pull-ups only on inputs
      pullUpOn        = pu_ff & dir_ff;
      pullUpOn.port13 = RST_PU;
   end

   assign analogInputs = asel_ff[3:0] & dir_ff.port2[3:0];
   assign memRdData    = rdData_ff;
   assign memRdValid   = rdValid_ff;

endmodule : gpc_port_regs

// [bench/gpc_port_asserts.sv]
// ------
// Port register and pin checks
// ------
module gpc_port_asserts (
   // Clock and reset
   input wire logic                    sys_clk,
   input wire logic                    sys_rst,
   // Core access
   input wire logic [15:0]             memAddr,
   input wire logic                    memRdEn,
   input wire logic                    memByteWr,
   input wire logic                    memBitWr,
   input wire logic [7:0]              memWrData,
   input wire logic [2:0]              memBitSel,
   input wire logic                    memBitVal,
   input wire logic [7:0]              memRdData,
   input wire logic                    memRdValid,
   // Pins and routing
   input wire gpc_port_pkg::gpc_pins_s pinOut,
   input wire gpc_port_pkg::gpc_pins_s pinOe,
   input wire gpc_port_pkg::gpc_pins_s pullUpOn,
   input wire logic [3:0]              analogInputs
);
   import gpc_port_pkg::*;
   // Pin positions that own a latch or a pull-up
   localparam logic [39:0] LATCH_BITS = {MASK_PORT2, MASK_PORT3WR, MASK_PORT4, MASK_PORT12, 8'h01};
   localparam logic [39:0] PU_BITS    = {8'h0F, 8'h03, 8'h3F, MASK_PULL_UP_ENABLE_PORT12, 8'h00};
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   rd_valid_pulse_a: assert property (memRdValid == $past(memRdEn))
      else $error("read valid not one cycle after request");
   unused_bits_zero_a: assert property (((pinOut | pinOe) & ~LATCH_BITS) == 40'h0)
      else $error("unimplemented pin driven");
   byte_write_latch_a: assert property (memByteWr && memAddr == ADDR_PORT2_DATA |=>
      pinOut.port2 == ($past(memWrData) & MASK_PORT2)) else $error("port 2 latch wrong");
   bit_write_latch_a: assert property (memBitWr && !memByteWr && memAddr == ADDR_PORT4_DATA
      |=> pinOut.port4[$past(memBitSel)] == ($past(memBitVal) & MASK_PORT4[$past(memBitSel)]))
      else $error("port 4 bit write wrong");
   dir_sets_oe_a: assert property (memByteWr && memAddr == ADDR_DIR_PORT4 |=>
      pinOe.port4 == (~$past(memWrData) & MASK_PORT4)) else $error("port 4 enable wrong");
   analog_select_a: assert property (memByteWr && memAddr == ADDR_ANALOG_SEL &&
      pinOe.port2[3:0] == 4'h0 |=> analogInputs == $past(memWrData[3:0]))
      else $error("analog routing wrong");
   input_only_gate_a: assert property (((pullUpOn & pinOe) == 40'h0) &&
      ((analogInputs & pinOe.port2[3:0]) == 4'h0)) else $error("driven pin pulled or routed");
   pullup_bits_a: assert property ((pullUpOn & ~PU_BITS) == 40'h0)
      else $error("pull-up on pin without one");
   out_port_read_a: assert property (memRdEn && memAddr == ADDR_PORT13_DATA |=>
      memRdData == $past(pinOut.port13)) else $error("output-only port read wrong");
endmodule : gpc_port_asserts

bind gpc_port_regs gpc_port_asserts u_asserts (.sys_clk, .sys_rst, .memAddr, .memRdEn,
   .memByteWr, .memBitWr, .memWrData, .memBitSel, .memBitVal, .memRdData, .memRdValid,
   .pinOut, .pinOe, .pullUpOn, .analogInputs);

// [bench/gpc_pin_model.sv]
// ------
// External circuitry on the port pins
// ------
module gpc_pin_model (
   // Clock
   input wire logic                    sys_clk,
   // Device side
   input wire gpc_port_pkg::gpc_pins_s pinOut,
   input wire gpc_port_pkg::gpc_pins_s pinOe,
   input wire gpc_port_pkg::gpc_pins_s pullUpOn,
   // Bench-controlled outside drivers
   input wire logic [39:0]             extDrv,
   input wire logic [39:0]             extVal,
   output gpc_port_pkg::gpc_pins_s     pinIn
);
   import gpc_port_pkg::*;
   logic [39:0] noise = 40'h5A5A5A5A5A;   // A floating line wanders every cycle
   always @(posedge sys_clk) begin
      noise <= ~noise;
   end
   // Device output wins, then the outside driver, then the pull-up, else noise
   assign pinIn = (pinOe & pinOut) | (~pinOe & extDrv & extVal) |
                  (~pinOe & ~extDrv & (pullUpOn | noise));
endmodule : gpc_pin_model

// [bench/tb_top.sv]
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import gpc_port_pkg::*;
   // ------
   // Bench state
   // ------
   logic        sys_clk, sys_rst, memRdEn, memByteWr, memBitWr, memBitVal, memRdValid;
   logic [15:0] memAddr;
   logic [7:0]  memWrData, memRdData, d, e;
   logic [2:0]  memBitSel, s;
   logic [3:0]  analogInputs;
   logic [39:0] extDrv, extVal;          // Outside drivers per pin
   gpc_pins_s   pinIn, pinOut, pinOe, pullUpOn;
   logic [7:0]  expQ[$];                 // Expected read answers, oldest first
   int          miscompares = 0, checks = 0, seed = 37517;
   // Tables for ports 2, 3, 4 and 12
   logic [15:0] dA[4] = '{ADDR_PORT2_DATA, ADDR_PORT3_DATA, ADDR_PORT4_DATA, ADDR_PORT12_DATA};
   logic [15:0] mA[4] = '{ADDR_DIR_PORT2, ADDR_DIR_PORT3, ADDR_DIR_PORT4, ADDR_DIR_PORT12};
   logic [15:0] uA[4] = '{ADDR_PU_PORT2, ADDR_PU_PORT3, ADDR_PU_PORT4, ADDR_PU_PORT12};
   logic [7:0]  wM[4] = '{MASK_PORT2, MASK_PORT3WR, MASK_PORT4, MASK_PORT12};
   logic [7:0]  rM[4] = '{MASK_PORT2, MASK_PORT3, MASK_PORT4, MASK_PORT12};
   logic [7:0]  uM[4] = '{8'h0F, 8'h03, 8'h3F, MASK_PULL_UP_ENABLE_PORT12};
   gpc_port_regs DUT (.sys_clk, .sys_rst, .memAddr, .memRdEn, .memByteWr, .memBitWr,
      .memWrData, .memBitSel, .memBitVal, .memRdData, .memRdValid, .pinIn, .pinOut,
      .pinOe, .pullUpOn, .analogInputs);
   gpc_pin_model farSide (.sys_clk, .pinOut, .pinOe, .pullUpOn, .extDrv, .extVal, .pinIn);
   // Byte of one port out of a pin group
   function automatic logic [7:0] pb(input logic [39:0] v, input int i);
      return v[39-8*i -: 8];
   endfunction : pb
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   // One access: strobes raised for a single cycle, read answer noted
   task automatic acc(input logic r, b, t, input logic [15:0] a, input logic [7:0] w,
                      input logic [2:0] bs, input logic bv, input logic [7:0] x);
      @(negedge sys_clk);
      {memRdEn, memByteWr, memBitWr} = {r, b, t};
      {memAddr, memWrData, memBitSel, memBitVal} = {a, w, bs, bv};
      if (r) expQ.push_back(x);
      @(negedge sys_clk);
      {memRdEn, memByteWr, memBitWr} = 3'h0;
   endtask : acc
   task automatic wr(input logic [15:0] a, input logic [7:0] w);
      acc(1'b0, 1'b1, 1'b0, a, w, 3'h0, 1'b0, 8'h00);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] x);
      acc(1'b1, 1'b0, 1'b0, a, 8'h00, 3'h0, 1'b0, x);
   endtask : rd
   // Values every register and output takes after reset
   task automatic chk_reset;
      for (int i = 0; i < 5; i++) begin
         cmp(pb(pinOut, i), RST_LATCH);
         cmp(pb(pinOe, i), (i == 4) ? 8'h01 : 8'h00);
         cmp(pb(pullUpOn, i), RST_PU);
      end
      for (int i = 0; i < 4; i++) begin
         rd(mA[i], RST_DIR);
         rd(uA[i], RST_PU);
      end
      rd(ADDR_ANALOG_SEL, RST_ASEL);
      cmp({4'h0, analogInputs}, 8'h00);
   endtask : chk_reset
   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Each read answer is matched with the oldest note
   always @(negedge sys_clk) begin
      if (memRdValid === 1'b1)
         cmp(memRdData, (expQ.size() > 0) ? expQ.pop_front() : 8'hXX);
   end
   // ------
   // Main sequence
   // ------
   initial begin
      {memAddr, memWrData, memBitSel, memBitVal, memRdEn, memByteWr, memBitWr} = '0;
      extDrv = '1;
      extVal = '0;
      sys_rst = 1'b1;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk_reset();
      for (int i = 0; i < 4; i++) begin
         // Output mode: latch drives the pin, bit write, read beside write
         d = 8'($random(seed));
         s = 3'($random(seed));
         wr(mA[i], 8'h00);
         wr(dA[i], d);
         cmp(pb(pinOut, i), d & wM[i]);
         cmp(pb(pinOe, i), wM[i]);
         acc(1'b0, 1'b0, 1'b1, dA[i], 8'h00, s, ~d[s], 8'h00);
         d[s] = ~d[s];
         cmp(pb(pinOut, i), d & wM[i]);
         acc(1'b1, 1'b1, 1'b0, dA[i], ~d, 3'h0, 1'b0, d & wM[i]);
         cmp(pb(pinOut, i), ~d & wM[i]);
         // Input mode: pin level shows after the synchroniser
         e = 8'($random(seed));
         extVal[39-8*i -: 8] = e;
         wr(mA[i], 8'hFF);
         repeat (6) @(negedge sys_clk);
         rd(dA[i], e & rM[i]);
         // Pull-ups follow the enable only while the pin is an input
         wr(uA[i], 8'hFF);
         cmp(pb(pullUpOn, i), uM[i]);
         rd(uA[i], uM[i]);
         wr(mA[i], 8'h00);
         cmp(pb(pullUpOn, i), 8'h00);
         wr(mA[i], 8'hFF);
      end
      wr(ADDR_PORT13_DATA, 8'hFF);
      cmp(pinOut.port13, MASK_PORT13);
      rd(ADDR_PORT13_DATA, MASK_PORT13);
      acc(1'b0, 1'b1, 1'b1, ADDR_PORT4_DATA, 8'h2A, 3'h0, 1'b1, 8'h00);
      cmp(pinOut.port4, 8'h2A);
      // Released port 4 lines rise on their enabled pull-ups
      extDrv[23:16] = 8'h00;
      repeat (6) @(negedge sys_clk);
      rd(ADDR_PORT4_DATA, MASK_PORT4);
      // Serial transmit pin: latch already high when its buffer turns on
      wr(ADDR_DIR_PORT4, 8'hF7);
      cmp(pinOe.port4, 8'h08);
      cmp({7'h00, pinIn.port4[3]}, 8'h01);
      cmp(pullUpOn.port4, 8'h37);
      wr(ADDR_DIR_PORT4, 8'hFF);
      extDrv[23:16] = 8'hFF;
      // Analog routing by bit and by byte, withdrawn for outputs
      acc(1'b0, 1'b0, 1'b1, ADDR_ANALOG_SEL, 8'h00, 3'h2, 1'b1, 8'h00);
      cmp({4'h0, analogInputs}, 8'h04);
      wr(ADDR_ANALOG_SEL, 8'hFF);
      rd(ADDR_ANALOG_SEL, 8'h0F);
      cmp({4'h0, analogInputs}, 8'h0F);
      wr(ADDR_DIR_PORT2, 8'h00);
      cmp({4'h0, analogInputs}, 8'h00);
      wr(16'hFF50, 8'hFF);
      rd(16'hFF50, RD_NONE);
      // Second reset in mid-run
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      chk_reset();
      repeat (2) @(negedge sys_clk);
      if (expQ.size() != 0) miscompares++;
      finish_test();
   end
endmodule : tb_top
